//--- src/irq_pkg.sv
// Purpose: Constants for the interrupt source and dispatch block
// Assumes: APB byte addresses, 32-bit words, registers in low bits (8 bits, priority registers 12 bits)
// Notes:   Twelve sources, four priority levels
package irq_pkg;
  localparam int          NUM_SRC       = 12;
  localparam int          SRC_W         = 4;
  localparam int          LVL_W         = 2;
  localparam logic [7:0]  ADDR_TIMER_AND_EXT_INT_CONTROL     = 8'h00;  // timer_and_ext_int_control
  localparam logic [7:0]  ADDR_IE       = 8'h04;  // main_int_mask
  localparam logic [7:0]  ADDR_WDOG_CONTROL    = 8'h08;  // wdog_control
  localparam logic [7:0]  ADDR_EIE      = 8'h0C;  // extended_int_mask
  localparam logic [7:0]  ADDR_PRIO_LO  = 8'h10;  // low priority bits, 12 sources
  localparam logic [7:0]  ADDR_PRIO_HI  = 8'h14;  // high priority bits, 12 sources
  localparam logic [7:0]  ADDR_FLAGS    = 8'h18;  // other source flags
  localparam logic [7:0]  ADDR_KEY      = 8'h1C;  // timed_access_key
  localparam logic [7:0]  ADDR_STATUS   = 8'h20;  // in-service levels, read only
  localparam logic [7:0]  KEY_FIRST     = 8'hAA;
  localparam logic [7:0]  KEY_SECOND    = 8'h55;
  localparam logic [7:0]  RESET_ZERO    = 8'h00;
  localparam logic [2:0]  KEY_WINDOW    = 3'h3;
  // Control register bit positions
  localparam int B_IE0 = 1;
  localparam int B_IT0 = 0;
  localparam int B_IE1 = 3;
  localparam int B_IT1 = 2;
  localparam int B_TF0 = 5;
  localparam int B_TF1 = 7;
  localparam int B_EA  = 7;
  localparam int B_WDOG_RUN = 7;
  localparam int B_WD1   = 5;
  localparam int B_WD0   = 4;
  localparam int B_WDOG_TIMEOUT_FLAG  = 3;
  localparam int B_WDOG_RESET_CAUSE_FLAG  = 2;
  localparam int B_WDOG_RESET_ENABLE = 1;
  localparam int B_WDOG_CLEAR_CMD = 0;
  localparam logic [7:0] WDOG_CONTROL_PROT = 8'hBB;  // Run, sel, flag, enable, clear
  // Source indices in arbitration order, index 0 ranked highest
  localparam int S_EX0 = 0;
  localparam int S_BO  = 1;
  localparam int S_WD  = 2;
  localparam int S_T0  = 3;
  localparam int S_TW  = 4;
  localparam int S_EX1 = 5;
  localparam int S_KB  = 6;
  localparam int S_CM1 = 7;
  localparam int S_T1  = 8;
  localparam int S_CM2 = 9;
  localparam int S_SER = 10;
  localparam int S_BRK = 11;
  // Flags register bit positions
  localparam int F_RX  = 0;
  localparam int F_TX  = 1;
  localparam int F_CM1 = 2;
  localparam int F_CM2 = 3;
  localparam int F_TW  = 4;
  localparam int F_BRK = 5;
  localparam int F_BO  = 6;
  localparam int F_KB  = 7;
  // Enable bit of each source: low three bits index into main mask, bit 4 selects extended
  localparam logic [4:0] EN_MAP [NUM_SRC] = '{5'h00, 5'h05, 5'h14, 5'h01, 5'h10, 5'h02,
                                              5'h11, 5'h12, 5'h03, 5'h13, 5'h04, 5'h15};
  localparam logic [15:0] VEC_MAP [NUM_SRC] = '{16'h0003, 16'h002B, 16'h0053, 16'h000B,
                                                16'h0033, 16'h0013, 16'h003B, 16'h0063,
                                                16'h001B, 16'h0043, 16'h0023, 16'h0073};
  typedef enum logic [1:0] {RC_EXT, RC_WDOG, RC_POR} reset_cause_e;
endpackage : irq_pkg

//--- src/irq_dispatch.sv
// Purpose: Interrupt source collection, gating, priority resolution and call
// Assumes: mc_tick marks each machine cycle; inputs synchronous to pclk
// Notes:   Registers over APB; watchdog control under timed access
`timescale 1ns/1ps
`default_nettype none
module irq_dispatch
  import irq_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [1:0]  reset_cause,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        mc_tick,
  input  wire logic        ext_request_pin_0,
  input  wire logic        ext_request_pin_1,
  input  wire logic        timer0_overflow,
  input  wire logic        timer1_overflow,
  input  wire logic        wdog_timeout,
  input  wire logic        rx_done,
  input  wire logic        tx_done,
  input  wire logic        comparator_toggle_1,
  input  wire logic        comparator_toggle_2,
  input  wire logic        two_wire_status_new,
  input  wire logic        brake_event,
  input  wire logic        brownout_event,
  input  wire logic        keyboard_event,
  input  wire logic        last_cycle,
  input  wire logic        insn_blocks_call,
  input  wire logic        return_from_isr,
  output logic             call_req,
  output logic      [15:0] call_vector,
  output logic             call_pushes_psw,
  output logic      [7:0]  wdog_control_out
);

  typedef struct packed {
    logic [7:0]         timer_and_ext_int_control;
    logic [7:0]         ie;
    logic [7:0]         wdog_control;
    logic [7:0]         extended_int_mask;
    logic [NUM_SRC-1:0] plo;
    logic [NUM_SRC-1:0] phi;
    logic [7:0]         flags;
    logic [1:0]         key_state;
    logic [2:0]         key_cnt;
    logic [1:0]         samp;
    logic [3:0]         in_svc;
    logic               call;
    logic [15:0]        vec;
    logic [31:0]        rdata;
    logic               cause_taken;
  } state_s;

  state_s q;
  state_s d;

  logic [NUM_SRC-1:0] req;
  logic [NUM_SRC-1:0] en;
  logic [LVL_W-1:0]   lvl [NUM_SRC];
  logic               wr;
  logic               rd;
  logic               unlocked;
  logic [7:0]         wb;
  logic               acc_wait;

  // Writes land only at the edge where pready is sampled high, never twice
  assign wr = psel && penable && pwrite && acc_wait;
  assign rd = psel && penable && !pwrite;
  assign wb = pwdata[7:0];
  assign unlocked = (q.key_state == 2'd2);

  // Raw requests in ranking order
  always_comb begin
    req = '0;
    req[S_EX0] = q.timer_and_ext_int_control[B_IE0];
    req[S_BO]  = q.flags[F_BO];
    req[S_WD]  = q.wdog_control[B_WDOG_TIMEOUT_FLAG];
    req[S_T0]  = q.timer_and_ext_int_control[B_TF0];
    req[S_TW]  = q.flags[F_TW];
    req[S_EX1] = q.timer_and_ext_int_control[B_IE1];
    req[S_KB]  = q.flags[F_KB];
    req[S_CM1] = q.flags[F_CM1];
    req[S_T1]  = q.timer_and_ext_int_control[B_TF1];
    req[S_CM2] = q.flags[F_CM2];
    req[S_SER] = q.flags[F_RX] | q.flags[F_TX];
    req[S_BRK] = q.flags[F_BRK];
  end

  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g++) begin : g_src
      assign en[g]  = q.ie[B_EA] && (EN_MAP[g][4] ? q.extended_int_mask[EN_MAP[g][2:0]]
                                                  : q.ie[EN_MAP[g][2:0]]);
      assign lvl[g] = {q.phi[g], q.plo[g]};
    end
  endgenerate

  // Pick winner: highest level first, lowest index within a level
  logic               found;
  logic [SRC_W-1:0]   win;
  logic [LVL_W-1:0]   win_lvl;
  logic               preempt_ok;
  always_comb begin
    found   = 1'b0;
    win     = '0;
    win_lvl = '0;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (req[i] && en[i] && (!found || lvl[i] > win_lvl)) begin
        found   = 1'b1;
        win     = SRC_W'(i);
        win_lvl = lvl[i];
      end
    end
    preempt_ok = 1'b1;
    for (int l = 0; l < 4; l++) begin
      if (q.in_svc[l] && l >= int'(win_lvl)) begin
        preempt_ok = 1'b0;
      end
    end
  end

  logic take;
  assign take = mc_tick && found && preempt_ok && last_cycle && !insn_blocks_call;

  logic [2:0] top_svc;
  always_comb begin
    top_svc = 3'd4;
    for (int l = 0; l < 4; l++) begin
      if (q.in_svc[l]) begin
        top_svc = 3'(l);
      end
    end
  end

  always_comb begin
    d = q;
    d.call = 1'b0;
    d.cause_taken = 1'b1;
    // Reset cause caught one clock after release, not under the async reset
    if (!q.cause_taken) begin
      if (reset_cause == 2'(RC_WDOG)) begin
        d.wdog_control[B_WDOG_RESET_CAUSE_FLAG] = 1'b1;
      end else if (reset_cause == 2'(RC_POR)) begin
        d.wdog_control[B_WDOG_RESET_CAUSE_FLAG] = 1'b0;
      end
    end
    // Timed access: two key writes open a short window
    if (q.key_cnt != 3'h0) begin
      d.key_cnt = q.key_cnt - 3'h1;
    end else if (q.key_state != 2'd0) begin
      d.key_state = 2'd0;
    end
    // Software writes come first so hardware events win over a clear
    if (wr) begin
      case (paddr)
        ADDR_TIMER_AND_EXT_INT_CONTROL:    d.timer_and_ext_int_control  = wb;
        ADDR_IE:      d.ie    = wb;
        ADDR_EIE:     d.extended_int_mask   = wb;
        ADDR_PRIO_LO: d.plo   = pwdata[NUM_SRC-1:0];
        ADDR_PRIO_HI: d.phi   = pwdata[NUM_SRC-1:0];
        ADDR_FLAGS:   d.flags = wb;
        ADDR_WDOG_CONTROL: begin
          d.wdog_control = (q.wdog_control & WDOG_CONTROL_PROT) | (wb & ~WDOG_CONTROL_PROT);
          if (unlocked) begin
            d.wdog_control = (wb & WDOG_CONTROL_PROT) | (d.wdog_control & ~WDOG_CONTROL_PROT);
          end
          d.key_state = 2'd0;
        end
        ADDR_KEY: begin
          if (wb == KEY_FIRST) begin
            d.key_state = 2'd1;
            d.key_cnt   = KEY_WINDOW;
          end else if (wb == KEY_SECOND && q.key_state == 2'd1) begin
            d.key_state = 2'd2;
            d.key_cnt   = KEY_WINDOW;
          end else begin
            d.key_state = 2'd0;
          end
        end
        default: ;
      endcase
    end
    // Machine-cycle sampling of external pins
    if (mc_tick) begin
      d.samp = {ext_request_pin_1, ext_request_pin_0};
      if (q.timer_and_ext_int_control[B_IT0]) begin
        if (q.samp[0] && !ext_request_pin_0) d.timer_and_ext_int_control[B_IE0] = 1'b1;
      end else begin
        d.timer_and_ext_int_control[B_IE0] = !ext_request_pin_0;
      end
      if (q.timer_and_ext_int_control[B_IT1]) begin
        if (q.samp[1] && !ext_request_pin_1) d.timer_and_ext_int_control[B_IE1] = 1'b1;
      end else begin
        d.timer_and_ext_int_control[B_IE1] = !ext_request_pin_1;
      end
    end
    if (take) begin
      d.call = 1'b1;
      d.vec  = VEC_MAP[win];
      d.in_svc[win_lvl] = 1'b1;
      if (win == SRC_W'(S_EX0) && q.timer_and_ext_int_control[B_IT0]) d.timer_and_ext_int_control[B_IE0] = 1'b0;
      if (win == SRC_W'(S_EX1) && q.timer_and_ext_int_control[B_IT1]) d.timer_and_ext_int_control[B_IE1] = 1'b0;
      if (win == SRC_W'(S_T0)) d.timer_and_ext_int_control[B_TF0] = 1'b0;
      if (win == SRC_W'(S_T1)) d.timer_and_ext_int_control[B_TF1] = 1'b0;
    end else if (return_from_isr && top_svc != 3'd4) begin
      d.in_svc[top_svc[1:0]] = 1'b0;
    end
    // Hardware set events, placed last so a set beats a same-cycle clear
    if (timer0_overflow)     d.timer_and_ext_int_control[B_TF0]  = 1'b1;
    if (timer1_overflow)     d.timer_and_ext_int_control[B_TF1]  = 1'b1;
    if (wdog_timeout)        d.wdog_control[B_WDOG_TIMEOUT_FLAG] = 1'b1;
    if (rx_done)             d.flags[F_RX]  = 1'b1;
    if (tx_done)             d.flags[F_TX]  = 1'b1;
    if (comparator_toggle_1) d.flags[F_CM1] = 1'b1;
    if (comparator_toggle_2) d.flags[F_CM2] = 1'b1;
    if (two_wire_status_new) d.flags[F_TW]  = 1'b1;
    if (brake_event)         d.flags[F_BRK] = 1'b1;
    if (brownout_event)      d.flags[F_BO]  = 1'b1;
    if (keyboard_event)      d.flags[F_KB]  = 1'b1;
    // Read data registered at the access phase
    d.rdata = '0;
    if (rd) begin
      case (paddr)
        ADDR_TIMER_AND_EXT_INT_CONTROL:    d.rdata = {24'h0, q.timer_and_ext_int_control};
        ADDR_IE:      d.rdata = {24'h0, q.ie};
        ADDR_WDOG_CONTROL:   d.rdata = {24'h0, q.wdog_control};
        ADDR_EIE:     d.rdata = {24'h0, q.extended_int_mask};
        ADDR_PRIO_LO: d.rdata = {20'h0, q.plo};
        ADDR_PRIO_HI: d.rdata = {20'h0, q.phi};
        ADDR_FLAGS:   d.rdata = {24'h0, q.flags};
        ADDR_KEY:     d.rdata = {30'h0, q.key_state};
        ADDR_STATUS:  d.rdata = {28'h0, q.in_svc};
        default:      d.rdata = '0;
      endcase
    end
  end

  // Async reset covers any reset: it clears the cause bit too, and only a watchdog cause sets it again after release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Reads answer one edge late, so the access phase waits one extra cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_wait <= 1'b0;
    end else begin
      acc_wait <= psel && penable && !acc_wait;
    end
  end

  logic bad_addr;
  always_comb begin
    case (paddr)
      ADDR_TIMER_AND_EXT_INT_CONTROL, ADDR_IE, ADDR_WDOG_CONTROL, ADDR_EIE, ADDR_PRIO_LO, ADDR_PRIO_HI,
      ADDR_FLAGS, ADDR_KEY, ADDR_STATUS: bad_addr = 1'b0;
      default:                           bad_addr = 1'b1;
    endcase
  end

  assign pready           = acc_wait;
  assign pslverr          = acc_wait && bad_addr;
  assign prdata           = q.rdata;
  assign call_req         = q.call;
  assign call_vector      = q.vec;
  assign call_pushes_psw  = 1'b0;
  assign wdog_control_out = q.wdog_control;

endmodule : irq_dispatch
`default_nettype wire

//--- tb/irq_dispatch_assertions.sv
// Purpose: Port-level checks for irq_dispatch
// Assumes: One pclk domain, reset cause held steady around reset release
// Notes:   Bound into every irq_dispatch instance
`timescale 1ns/1ps
`default_nettype none
module irq_dispatch_assertions
  import irq_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [1:0]  reset_cause,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        mc_tick,
  input wire logic        last_cycle,
  input wire logic        insn_blocks_call,
  input wire logic        wdog_timeout,
  input wire logic        call_req,
  input wire logic [15:0] call_vector,
  input wire logic        call_pushes_psw,
  input wire logic [7:0]  wdog_control_out
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Write to the watchdog control register taking effect
  wire logic wd_wr = psel && penable && pwrite && pready && paddr == ADDR_WDOG_CONTROL;
  call_gate_a: assert property (call_req |-> $past(mc_tick && last_cycle && !insn_blocks_call))
    else $error("call outside a permitted poll");
  call_pulse_a: assert property (call_req |=> !call_req)
    else $error("call request longer than one cycle");
  no_psw_a: assert property (call_pushes_psw == 1'b0)
    else $error("status word pushed");
  vec_form_a: assert property (call_req |-> call_vector[15:7] == 9'h000 && call_vector[2:0] == 3'h3)
    else $error("vector outside the table");
  wdog_timeout_flag_set_a: assert property (wdog_timeout |=> wdog_control_out[B_WDOG_TIMEOUT_FLAG])
    else $error("timeout flag not set");
  wdog_timeout_flag_clr_a: assert property ($fell(wdog_control_out[B_WDOG_TIMEOUT_FLAG]) |-> $past(wd_wr))
    else $error("timeout flag lost without a write");
  prot_bits_a: assert property ((wdog_control_out & 8'hB2) != $past(wdog_control_out & 8'hB2) |-> $past(wd_wr))
    else $error("protected bit changed without a write");
  reset_cause_a: assert property ($rose(presetn) |-> ##[1:2] wdog_control_out[B_WDOG_RESET_CAUSE_FLAG] == (reset_cause == RC_WDOG))
    else $error("reset cause bit wrong");
  cover property (call_req);
  cover property (pready && pslverr);
  cover property (wdog_timeout);
endmodule : irq_dispatch_assertions
bind irq_dispatch irq_dispatch_assertions u_chk (.*);
`default_nettype wire

//--- tb/core_model.sv
// Purpose: Core side: machine-cycle strobe and final-cycle flag
// Assumes: Four clocks to a machine cycle
// Notes:   Bench can hold an instruction in mid-flight
`timescale 1ns/1ps
`default_nettype none
module core_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic hold_last,
  output logic      mc_tick,
  output logic      last_cycle
);
  logic [1:0] phase;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) phase <= 2'h0;
    else phase <= phase + 2'h1;
  end
  assign mc_tick    = phase == 2'h3;
  assign last_cycle = !hold_last;
endmodule : core_model
`default_nettype wire

//--- tb/interrupt_source_and_dispatch_tb.sv
// Purpose: Self-checking bench for irq_dispatch
// Assumes: APB answers after one access cycle or more; core model gives ticks
// Notes:   Ordinary sources as table rows, awkward cases after
`timescale 1ns/1ps
`default_nettype none
module interrupt_source_and_dispatch_tb;
  import irq_pkg::*;
  typedef struct {int i; logic [7:0] ie, extended_int_mask, flg; logic [15:0] vec;} row_s;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic pin0 = 1'b1, pin1 = 1'b1, blk = 1'b0, ret = 1'b0, hold = 1'b0, rerr;
  logic [1:0] cause = RC_EXT;
  logic [7:0] paddr = 8'h00;
  logic [10:0] ev = 11'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdata;
  logic pready, pslverr, mc_tick, last_cycle, call_req, psw;
  logic [15:0] call_vector;
  logic [7:0] wdo;
  int n_mismatch = 0, total_checks = 0;
  row_s rows [10] = '{'{1, 8'h88, 8'h00, 8'h00, 16'h001B}, '{3, 8'h90, 8'h00, 8'h01, 16'h0023},
    '{4, 8'h90, 8'h00, 8'h02, 16'h0023}, '{9, 8'hA0, 8'h00, 8'h40, 16'h002B},
    '{7, 8'h80, 8'h01, 8'h10, 16'h0033}, '{10, 8'h80, 8'h02, 8'h80, 16'h003B},
    '{6, 8'h80, 8'h08, 8'h08, 16'h0043}, '{5, 8'h80, 8'h04, 8'h04, 16'h0063},
    '{8, 8'h80, 8'h20, 8'h20, 16'h0073}, '{2, 8'h80, 8'h10, 8'h00, 16'h0053}};
  initial begin
    forever #5 pclk = ~pclk;
  end
  irq_dispatch DUT (.pclk(pclk), .presetn(presetn), .reset_cause(cause), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mc_tick(mc_tick), .ext_request_pin_0(pin0), .ext_request_pin_1(pin1), .timer0_overflow(ev[0]),
    .timer1_overflow(ev[1]), .wdog_timeout(ev[2]), .rx_done(ev[3]), .tx_done(ev[4]),
    .comparator_toggle_1(ev[5]), .comparator_toggle_2(ev[6]), .two_wire_status_new(ev[7]),
    .brake_event(ev[8]), .brownout_event(ev[9]), .keyboard_event(ev[10]), .last_cycle(last_cycle),
    .insn_blocks_call(blk), .return_from_isr(ret), .call_req(call_req), .call_vector(call_vector),
    .call_pushes_psw(psw), .wdog_control_out(wdo));
  core_model u_core (.pclk(pclk), .presetn(presetn), .hold_last(hold), .mc_tick(mc_tick),
    .last_cycle(last_cycle));
  task automatic complete_run;
    if (n_mismatch == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : complete_run
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // Holding psel across calls keeps the key sequence inside its window
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d, input logic rel = 1'b1);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      n_mismatch++;
      complete_run();
    end
    rdata = prdata;
    rerr = pslverr;
    penable <= 1'b0;
    if (rel) begin
      psel <= 1'b0;
      @(posedge pclk);
    end
  endtask : apb
  task automatic pulse(input int k);
    ev[k] <= 1'b1;
    @(posedge pclk);
    ev <= 11'h000;
    @(posedge pclk);
  endtask : pulse
  task automatic give_back;
    ret <= 1'b1;
    @(posedge pclk);
    ret <= 1'b0;
    @(posedge pclk);
  endtask : give_back
  task automatic wait_call(input logic [15:0] v);
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (call_req !== 1'b1 && n < 40);
    if (call_req !== 1'b1) begin
      n_mismatch++;
      complete_run();
    end
    chk("vector", call_vector, v);
  endtask : wait_call
  task automatic quiet(input int n);
    repeat (n) begin
      @(posedge pclk);
      chk("no call", call_req, 0);
    end
  endtask : quiet
  task automatic do_reset(input logic [1:0] c);
    presetn <= 1'b0;
    cause <= c;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
  endtask : do_reset
  initial begin
    do_reset(RC_EXT);
    foreach (rows[k]) begin
      apb(1, ADDR_IE, rows[k].ie);
      apb(1, ADDR_EIE, rows[k].extended_int_mask);
      pulse(rows[k].i);
      wait_call(rows[k].vec);
      apb(0, ADDR_FLAGS, 0);
      chk("flags", rdata, rows[k].flg);
      apb(1, ADDR_IE, 0);
      apb(1, ADDR_EIE, 0);
      apb(1, ADDR_FLAGS, 0);
      give_back();
    end
    apb(1, ADDR_TIMER_AND_EXT_INT_CONTROL, 8'h01);
    apb(1, ADDR_IE, 8'h81);
    pin0 <= 1'b0;
    wait_call(16'h0003);
    apb(0, ADDR_TIMER_AND_EXT_INT_CONTROL, 0);
    chk("edge flag", rdata, 32'h1);
    give_back();
    pin0 <= 1'b1;
    apb(1, ADDR_TIMER_AND_EXT_INT_CONTROL, 0);
    pin0 <= 1'b0;
    wait_call(16'h0003);
    apb(0, ADDR_TIMER_AND_EXT_INT_CONTROL, 0);
    chk("level flag", rdata, 32'h2);
    give_back();
    wait_call(16'h0003);
    apb(1, ADDR_PRIO_LO, 8'h08);
    apb(1, ADDR_PRIO_HI, 8'h08);
    apb(1, ADDR_IE, 8'h83);
    pulse(0);
    wait_call(16'h000B);
    apb(0, ADDR_TIMER_AND_EXT_INT_CONTROL, 0);
    chk("overflow flag", rdata, 32'h2);
    pin0 <= 1'b1;
    apb(1, ADDR_IE, 0);
    give_back();
    give_back();
    apb(1, ADDR_PRIO_LO, 0);
    apb(1, ADDR_PRIO_HI, 0);
    apb(1, ADDR_TIMER_AND_EXT_INT_CONTROL, 8'h01);
    pin0 <= 1'b0;
    pulse(0);
    quiet(8);
    apb(1, ADDR_IE, 8'h83);
    wait_call(16'h0003);
    give_back();
    wait_call(16'h000B);
    apb(1, ADDR_IE, 8'h02);
    give_back();
    pin0 <= 1'b1;
    pulse(0);
    quiet(12);
    hold <= 1'b1;
    apb(1, ADDR_IE, 8'h82);
    quiet(12);
    hold <= 1'b0;
    blk <= 1'b1;
    quiet(12);
    blk <= 1'b0;
    wait_call(16'h000B);
    apb(1, ADDR_IE, 8'h90);
    give_back();
    apb(1, ADDR_FLAGS, 8'h01);
    wait_call(16'h0023);
    apb(1, ADDR_IE, 0);
    apb(1, ADDR_FLAGS, 0);
    give_back();
    do_reset(RC_EXT);
    for (int a = 0; a <= 8; a++) begin
      apb(0, 8'(a * 4), 0);
      chk("reset value", rdata, 0);
    end
    apb(0, 8'h24, 0);
    chk("unmapped error", rerr, 1);
    pulse(2);
    apb(1, ADDR_WDOG_CONTROL, 8'hFF);
    apb(0, ADDR_WDOG_CONTROL, 0);
    chk("locked write", rdata, 32'h4C);
    apb(1, ADDR_KEY, KEY_FIRST, 1'b0);
    apb(1, ADDR_KEY, KEY_SECOND, 1'b0);
    apb(1, ADDR_WDOG_CONTROL, 8'h02);
    apb(0, ADDR_WDOG_CONTROL, 0);
    chk("unlocked write", rdata, 32'h2);
    apb(1, ADDR_WDOG_CONTROL, 8'h80);
    apb(0, ADDR_WDOG_CONTROL, 0);
    chk("relocked", rdata, 32'h2);
    do_reset(RC_WDOG);
    apb(0, ADDR_WDOG_CONTROL, 0);
    chk("wdog reset", rdata, 32'h4);
    do_reset(RC_POR);
    apb(0, ADDR_WDOG_CONTROL, 0);
    chk("power-on reset", rdata, 32'h0);
    complete_run();
  end
endmodule : interrupt_source_and_dispatch_tb
`default_nettype wire
